// [core/ecsr_regs.svh]
// register layout, reset values and setting codes of the event status block
`ifndef ECSR_REGS_SVH
`define ECSR_REGS_SVH
`define ECSR_W 8
`define ECSR_NREG 4
`define ECSR_LERR 4
`define ECSR_PARITY_BIT 0
`define ECSR_FRAMING_BIT 1
`define ECSR_OVERRUN_BIT 2
`define ECSR_LERR_PAD 5'h00
`define ECSR_EV0_PAD 1'b0
`define ECSR_EV1_PAD 1'b0
`define ECSR_MASK_RST 8'h00
`define ECSR_MASK_MAX 17'h000ff
`define ECSR_FREQ_LO 17'h00078
`define ECSR_FREQ_HI 17'h003e8
`define ECSR_FREQ_RST 1'b1
`define ECSR_HDR_RST 1'b1
`define ECSR_HAND_RST HS_NONE
`define ECSR_HALF_BIT 3
`define ECSR_BIN_LO 2
`define ECSR_BIN_HI 3
`define ECSR_ZERO16 16'h0000
`endif

// [core/ecsr_pkg.sv]
// command codes and setting types of the event status block
package ecsr_pkg;
  typedef enum logic [3:0] {
    CMD_NONE, CMD_ERR_Q, CMD_ESE_W, CMD_ESE_Q, CMD_ESR_Q, CMD_FREQ_W,
    CMD_FREQ_Q, CMD_HAND_W, CMD_HAND_Q, CMD_HDR_W, CMD_HDR_Q
  } ecsr_cmd_t;
  typedef enum logic [1:0] {HS_SOFT, HS_HARD, HS_BOTH, HS_NONE} ecsr_hand_t;
endpackage : ecsr_pkg

// [core/ecsr_latch.sv]
// one 8-bit sticky event latch, cleared when read
`timescale 1ns/1ps
module ecsr_latch (
  input wire logic mclk_i,
  input wire logic resetn_i,
  input wire logic [7:0] set_i,
  input wire logic clear_i,
  output logic [7:0] flags_o
);
  logic [7:0] flags_r;
  logic [7:0] flags_nxt;

  // a set in the read cycle survives into the next read
  assign flags_nxt = (clear_i ? 8'h00 : flags_r) | set_i;
  assign flags_o = flags_r;

  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      flags_r <= 8'h00;
    end else begin
      flags_r <= flags_nxt;
    end
  end

  set_wins_a: assert property (
    @(posedge mclk_i) disable iff (!resetn_i)
    (set_i != 8'h00) |=> ((flags_r & $past(set_i)) == $past(set_i)))
    else $error("event set lost");
endmodule : ecsr_latch

// [core/ecsr_top.sv]
// event status, enable mask and link setting registers behind the command port
// What this block does
// - parity bit0, framing bit1, overrun bit2 latched
// - error query returns value, then clears
// - error and event replies never carry prefix
// - mask write accepts only 0 to 255
// - all masks zero after power-on
// - fractional argument rounded before storing
// - mask query returns mask, leaves it
// - mask reply prefixed only when header on
// - register 1: first, second, both-pass layout
// - register 2 holds sort classes 1-8
// - register 3: classes 9-14, reject, outside
// - event query returns value, then clears
// - without sorting, registers 2,3 read zero
// - frequency only 120 or 1000, queryable
// - handshake soft, hard, both or none
// - response header on after power-up
`timescale 1ns/1ps
`include "ecsr_regs.svh"
module ecsr_top import ecsr_pkg::*; #(
  parameter bit SORT_EN = 1'b1
) (
  input wire logic mclk_i,
  input wire logic resetn_i,
  input wire logic cmd_valid_i,
  input wire ecsr_cmd_t cmd_code_i,
  input wire logic [1:0] cmd_idx_i,
  input wire logic [15:0] cmd_int_i,
  input wire logic [3:0] cmd_frac_i,
  input wire ecsr_hand_t cmd_hand_i,
  input wire logic cmd_flag_i,
  input wire logic parity_err_i,
  input wire logic framing_err_i,
  input wire logic overrun_err_i,
  input wire logic [6:0] progress_evt_i,
  input wire logic [6:0] judge_evt_i,
  input wire logic [7:0] sort_lo_evt_i,
  input wire logic [7:0] sort_hi_evt_i,
  output logic rsp_valid_o,
  output logic [15:0] rsp_value_o,
  output logic rsp_keyword_o,
  output logic rsp_header_o,
  output logic cmd_reject_o,
  output logic freq_1k_o,
  output ecsr_hand_t handshake_o,
  output logic header_on_o,
  output logic [3:0] summary_o
);
  logic [7:0] mask_r [`ECSR_NREG];
  logic [7:0] mask_nxt [`ECSR_NREG];
  logic [7:0] flags [`ECSR_LERR+1];
  logic [7:0] sets [`ECSR_LERR+1];
  logic [`ECSR_LERR:0] clears;
  logic freq_r;
  logic freq_nxt;
  ecsr_hand_t hand_r;
  ecsr_hand_t hand_nxt;
  logic hdr_r;
  logic hdr_nxt;
  logic rsp_valid_r;
  logic [15:0] rsp_value_r;
  logic [15:0] rsp_value_nxt;
  logic rsp_kw_r;
  logic rsp_hdr_r;
  logic rsp_hdr_nxt;
  logic reject_r;
  logic reject_nxt;
  logic [3:0] summary_r;
  logic [3:0] summary_nxt;

  function automatic logic cmd_is(input logic v, input ecsr_cmd_t c,
                                  input ecsr_cmd_t want);
    cmd_is = v && (c == want);
  endfunction : cmd_is

  // the parser hands over integer and sixteenths; half rounds up
  wire [16:0] arg_rnd = {1'b0, cmd_int_i} +
    {16'h0000, cmd_frac_i[`ECSR_HALF_BIT]};
  wire mask_ok = arg_rnd <= `ECSR_MASK_MAX;
  wire freq_lo = arg_rnd == `ECSR_FREQ_LO;
  wire freq_hi = arg_rnd == `ECSR_FREQ_HI;
  wire is_err_q = cmd_is(cmd_valid_i, cmd_code_i, CMD_ERR_Q);
  wire is_ese_w = cmd_is(cmd_valid_i, cmd_code_i, CMD_ESE_W);
  wire is_ese_q = cmd_is(cmd_valid_i, cmd_code_i, CMD_ESE_Q);
  wire is_esr_q = cmd_is(cmd_valid_i, cmd_code_i, CMD_ESR_Q);
  wire is_freq_w = cmd_is(cmd_valid_i, cmd_code_i, CMD_FREQ_W);
  wire is_freq_q = cmd_is(cmd_valid_i, cmd_code_i, CMD_FREQ_Q);
  wire is_hand_w = cmd_is(cmd_valid_i, cmd_code_i, CMD_HAND_W);
  wire is_hand_q = cmd_is(cmd_valid_i, cmd_code_i, CMD_HAND_Q);
  wire is_hdr_w = cmd_is(cmd_valid_i, cmd_code_i, CMD_HDR_W);
  wire is_hdr_q = cmd_is(cmd_valid_i, cmd_code_i, CMD_HDR_Q);
  wire is_query = is_err_q | is_ese_q | is_esr_q | is_freq_q |
    is_hand_q | is_hdr_q;
  wire sort_on = SORT_EN;

  // link error flags: bits 3..7 stay zero
  assign sets[`ECSR_LERR] = {`ECSR_LERR_PAD, overrun_err_i, framing_err_i,
    parity_err_i};
  assign sets[0] = {`ECSR_EV0_PAD, progress_evt_i};
  assign sets[1] = {`ECSR_EV1_PAD, judge_evt_i};
  // sort flags never latch in the build without sorting
  assign sets[`ECSR_BIN_LO] = sort_on ? sort_lo_evt_i : 8'h00;
  assign sets[`ECSR_BIN_HI] = sort_on ? sort_hi_evt_i : 8'h00;
  assign clears[`ECSR_LERR] = is_err_q;

  genvar g;
  generate
    for (g = 0; g < `ECSR_NREG; g++) begin : g_reg
      assign clears[g] = is_esr_q && (cmd_idx_i == g);
      assign mask_nxt[g] = (is_ese_w && mask_ok && (cmd_idx_i == g)) ?
        arg_rnd[7:0] : mask_r[g];
      assign summary_nxt[g] = |(flags[g] & mask_r[g]);
      always_ff @(posedge mclk_i or negedge resetn_i) begin
        if (!resetn_i) begin
          mask_r[g] <= `ECSR_MASK_RST;
        end else begin
          mask_r[g] <= mask_nxt[g];
        end
      end
    end
    for (g = 0; g <= `ECSR_LERR; g++) begin : g_latch
      ecsr_latch u_latch (
        .mclk_i(mclk_i),
        .resetn_i(resetn_i),
        .set_i(sets[g]),
        .clear_i(clears[g]),
        .flags_o(flags[g])
      );
    end
  endgenerate

  assign freq_nxt = (is_freq_w && (freq_lo || freq_hi)) ? freq_hi :
    freq_r;
  assign hand_nxt = is_hand_w ? cmd_hand_i : hand_r;
  assign hdr_nxt = is_hdr_w ? cmd_flag_i : hdr_r;
  assign reject_nxt = (is_ese_w && !mask_ok) ||
    (is_freq_w && !(freq_lo || freq_hi));

  // error and event replies stay bare whatever the header setting
  assign rsp_hdr_nxt = hdr_r && !(is_err_q || is_esr_q);
  assign rsp_value_nxt =
    is_err_q ? {8'h00, flags[`ECSR_LERR]} :
    is_ese_q ? {8'h00, mask_r[cmd_idx_i]} :
    is_esr_q ? {8'h00, flags[cmd_idx_i]} :
    is_freq_q ? 16'(freq_r ? `ECSR_FREQ_HI : `ECSR_FREQ_LO) :
    is_hand_q ? {14'h0000, hand_r} :
    is_hdr_q ? {15'h0000, hdr_r} : `ECSR_ZERO16;

  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      freq_r <= `ECSR_FREQ_RST;
      hand_r <= `ECSR_HAND_RST;
      hdr_r <= `ECSR_HDR_RST;
      rsp_valid_r <= 1'b0;
      rsp_value_r <= `ECSR_ZERO16;
      rsp_kw_r <= 1'b0;
      rsp_hdr_r <= 1'b0;
      reject_r <= 1'b0;
      summary_r <= 4'h0;
    end else begin
      freq_r <= freq_nxt;
      hand_r <= hand_nxt;
      hdr_r <= hdr_nxt;
      rsp_valid_r <= is_query;
      rsp_value_r <= rsp_value_nxt;
      rsp_kw_r <= is_hand_q | is_hdr_q;
      rsp_hdr_r <= rsp_hdr_nxt;
      reject_r <= reject_nxt;
      summary_r <= summary_nxt;
    end
  end

  assign rsp_valid_o = rsp_valid_r;
  assign rsp_value_o = rsp_value_r;
  assign rsp_keyword_o = rsp_kw_r;
  assign rsp_header_o = rsp_hdr_r;
  assign cmd_reject_o = reject_r;
  assign freq_1k_o = freq_r;
  assign handshake_o = hand_r;
  assign header_on_o = hdr_r;
  assign summary_o = summary_r;

  // checks
  // one command per cycle, so a reply cycle never carries
  // a second write to the register that it reports
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!resetn_i);

  // link error register
  err_bits_a: assert property (
    (parity_err_i && !framing_err_i && !overrun_err_i) |=>
    flags[`ECSR_LERR][2:0] != 3'h0 &&
    flags[`ECSR_LERR][`ECSR_PARITY_BIT])
    else $error("parity fault not latched");

  err_frame_a: assert property (
    framing_err_i |=> flags[`ECSR_LERR][`ECSR_FRAMING_BIT])
    else $error("framing fault not latched");

  err_overrun_a: assert property (
    overrun_err_i |=> flags[`ECSR_LERR][`ECSR_OVERRUN_BIT])
    else $error("overrun not latched");

  err_unused_a: assert property (
    flags[`ECSR_LERR][7:3] == `ECSR_LERR_PAD)
    else $error("unused link error bit set");

  err_clear_a: assert property (
    (is_err_q && sets[`ECSR_LERR] == 8'h00) |=>
    rsp_valid_o && rsp_value_o == {8'h00, $past(flags[`ECSR_LERR])} &&
    flags[`ECSR_LERR] == 8'h00)
    else $error("error query reply or clear wrong");

  err_range_a: assert property (
    is_err_q |=> rsp_value_o <= 16'h0007)
    else $error("error reply above seven");

  // reply framing
  no_prefix_a: assert property (
    (is_err_q || is_esr_q) |=> rsp_valid_o && !rsp_header_o)
    else $error("prefix on error or event reply");

  reply_pulse_a: assert property (
    rsp_valid_o == $past(is_query))
    else $error("reply strobe not one cycle after query");

  kw_numeric_a: assert property (
    (is_err_q || is_ese_q || is_esr_q || is_freq_q) |=> !rsp_keyword_o)
    else $error("numeric reply marked as keyword");

  // enable masks and header setting
  mask_range_a: assert property (
    (is_ese_w && !mask_ok) |=> cmd_reject_o &&
    mask_r[$past(cmd_idx_i)] == $past(mask_r[cmd_idx_i]))
    else $error("out of range mask stored");

  power_on_a: assert property (
    $rose(resetn_i) |-> mask_r[0] == `ECSR_MASK_RST &&
    mask_r[1] == `ECSR_MASK_RST && mask_r[2] == `ECSR_MASK_RST &&
    mask_r[3] == `ECSR_MASK_RST && hdr_r == `ECSR_HDR_RST)
    else $error("power-on settings wrong");

  mask_round_a: assert property (
    (is_ese_w && mask_ok) |=> mask_r[$past(cmd_idx_i)] ==
    $past(cmd_int_i[7:0] + {7'h00, cmd_frac_i[`ECSR_HALF_BIT]}))
    else $error("mask write not rounded or stored");

  mask_query_a: assert property (
    (is_ese_q && !is_ese_w) |=>
    rsp_value_o == {8'h00, mask_r[$past(cmd_idx_i)]} &&
    rsp_header_o == $past(hdr_r))
    else $error("mask query reply wrong");

  mask_keep_a: assert property (
    is_ese_q |=> mask_r[$past(cmd_idx_i)] ==
    $past(mask_r[cmd_idx_i]))
    else $error("mask query changed the mask");

  hdr_follow_a: assert property (
    is_hdr_w |=> header_on_o == $past(cmd_flag_i))
    else $error("header setting not taken");

  // event latches
  ev0_layout_a: assert property (
    (progress_evt_i != 7'h00) |=>
    (flags[0][6:0] & $past(progress_evt_i)) == $past(progress_evt_i))
    else $error("progress event not latched in place");

  ev1_layout_a: assert property (
    (judge_evt_i != 7'h00) |=>
    (flags[1][6:0] & $past(judge_evt_i)) == $past(judge_evt_i))
    else $error("judgement event not latched in place");

  ev_unused_a: assert property (
    flags[0][7] == `ECSR_EV0_PAD && flags[1][7] == `ECSR_EV1_PAD)
    else $error("unused event bit set");

  ev2_layout_a: assert property (
    (sort_on && sort_lo_evt_i != 8'h00) |=>
    (flags[`ECSR_BIN_LO] & $past(sort_lo_evt_i)) == $past(sort_lo_evt_i))
    else $error("class 1 to 8 event not latched");

  ev3_layout_a: assert property (
    (sort_on && sort_hi_evt_i != 8'h00) |=>
    (flags[`ECSR_BIN_HI] & $past(sort_hi_evt_i)) == $past(sort_hi_evt_i))
    else $error("class 9 to 14 event not latched");

  esr_clear_a: assert property (
    (is_esr_q && sets[cmd_idx_i] == 8'h00) |=> rsp_valid_o &&
    rsp_value_o == {8'h00, $past(flags[cmd_idx_i])} &&
    flags[$past(cmd_idx_i)] == 8'h00)
    else $error("event register not cleared by query");

  bin_off_a: assert property (
    !sort_on |-> flags[`ECSR_BIN_LO] == 8'h00 &&
    flags[`ECSR_BIN_HI] == 8'h00)
    else $error("sort flags set without sorting");

  // link settings
  freq_set_a: assert property (
    (is_freq_w && freq_hi) |=> freq_1k_o ##1
    (freq_1k_o || $past(is_freq_w)))
    else $error("frequency 1000 not taken");

  freq_low_a: assert property (
    (is_freq_w && freq_lo) |=> !freq_1k_o)
    else $error("frequency 120 not taken");

  freq_keep_a: assert property (
    (is_freq_w && !(freq_lo || freq_hi)) |=> cmd_reject_o &&
    freq_1k_o == $past(freq_1k_o))
    else $error("illegal frequency taken");

  hand_set_a: assert property (
    is_hand_w |=> handshake_o == $past(cmd_hand_i))
    else $error("handshake setting not taken");

  hand_reply_a: assert property (
    is_hand_q |=> rsp_keyword_o &&
    rsp_value_o == {14'h0000, $past(handshake_o)})
    else $error("handshake reply wrong");

  // summary lags the latch by one cycle
  summary_gate_a: assert property (
    summary_o[1] == $past(|(flags[1] & mask_r[1])))
    else $error("summary not gated by mask");

  summary_mask_a: assert property (
    (mask_r[2] == 8'h00) |=> !summary_o[2])
    else $error("summary raised by masked event");

  summary_hit_a: assert property (
    ((flags[3] & mask_r[3]) != 8'h00) |=> summary_o[3])
    else $error("summary missing for enabled event");

  // scenarios worth seeing
  err_query_c: cover property (is_err_q ##1 rsp_value_o != 16'h0000);
  ese_write_c: cover property (is_ese_w && mask_ok ##1 summary_o != 4'h0);
  reject_c: cover property (cmd_reject_o);
  esr_clear_c: cover property (is_esr_q ##1 rsp_value_o != 16'h0000);
  hand_write_c: cover property (is_hand_w ##1 handshake_o != HS_NONE);
endmodule : ecsr_top

// [bench/ecsr_host.sv]
// host side model issuing one command at a time on the command port
`timescale 1ns/1ps
module ecsr_host import ecsr_pkg::*; (
  input wire logic mclk_i,
  output logic cmd_valid_o,
  output ecsr_cmd_t cmd_code_o,
  output logic [1:0] cmd_idx_o,
  output logic [15:0] cmd_int_o,
  output logic [3:0] cmd_frac_o,
  output ecsr_hand_t cmd_hand_o,
  output logic cmd_flag_o
);
  initial begin
    cmd_valid_o = 1'b0;
    cmd_code_o = CMD_NONE;
    cmd_idx_o = 2'h0;
    cmd_int_o = 16'h0000;
    cmd_frac_o = 4'h0;
    cmd_hand_o = HS_NONE;
    cmd_flag_o = 1'b0;
  end
  // returns 1 ns after the taking edge, when replies stand
  task automatic send(input ecsr_cmd_t c, input logic [1:0] i,
                      input logic [15:0] n, input logic [3:0] f,
                      input ecsr_hand_t h, input logic fl);
    @(posedge mclk_i);
    cmd_valid_o <= 1'b1;
    cmd_code_o <= c;
    cmd_idx_o <= i;
    cmd_int_o <= n;
    cmd_frac_o <= f;
    cmd_hand_o <= h;
    cmd_flag_o <= fl;
    @(posedge mclk_i);
    cmd_valid_o <= 1'b0;
    // stale integer, index and fraction are scrambled so a late sample cannot pass
    cmd_int_o <= ~n;
    cmd_idx_o <= ~i;
    cmd_frac_o <= ~f;
    #1;
  endtask : send
endmodule : ecsr_host

// [bench/ecsr_top_bench.sv]
// self-checking bench for the event status block
`timescale 1ns/1ps
module ecsr_top_bench import ecsr_pkg::*;;
  logic mclk_i = 1'b0;
  logic resetn_i = 1'b0;
  logic cv, ck, rh, rej, f1k, hon, pe = 0, fe = 0, oe = 0, cf, rv;
  ecsr_cmd_t cc;
  logic [1:0] ci;
  logic [15:0] cn, val;
  logic rv_ns;
  logic [15:0] val_ns;
  logic [3:0] cfr, sum;
  ecsr_hand_t ch, hs;
  logic [6:0] pg = 0, jd = 0;
  logic [7:0] second_param_low = 0, second_param_high = 0;
  int failures = 0;
  int compares = 0;
  ecsr_host host (.mclk_i(mclk_i), .cmd_valid_o(cv), .cmd_code_o(cc),
    .cmd_idx_o(ci), .cmd_int_o(cn), .cmd_frac_o(cfr), .cmd_hand_o(ch),
    .cmd_flag_o(cf));
  ecsr_top #(.SORT_EN(1'b1)) DUT (.mclk_i(mclk_i), .resetn_i(resetn_i),
    .cmd_valid_i(cv), .cmd_code_i(cc), .cmd_idx_i(ci), .cmd_int_i(cn),
    .cmd_frac_i(cfr), .cmd_hand_i(ch), .cmd_flag_i(cf),
    .parity_err_i(pe), .framing_err_i(fe), .overrun_err_i(oe),
    .progress_evt_i(pg), .judge_evt_i(jd), .sort_lo_evt_i(second_param_low),
    .sort_hi_evt_i(second_param_high), .rsp_valid_o(rv), .rsp_value_o(val),
    .rsp_keyword_o(ck), .rsp_header_o(rh), .cmd_reject_o(rej),
    .freq_1k_o(f1k), .handshake_o(hs), .header_on_o(hon), .summary_o(sum));
  // build without sorting, fed the same traffic
  ecsr_top #(.SORT_EN(1'b0)) nosort_dut (.mclk_i(mclk_i),
    .resetn_i(resetn_i), .cmd_valid_i(cv), .cmd_code_i(cc), .cmd_idx_i(ci),
    .cmd_int_i(cn), .cmd_frac_i(cfr), .cmd_hand_i(ch), .cmd_flag_i(cf),
    .parity_err_i(pe), .framing_err_i(fe), .overrun_err_i(oe),
    .progress_evt_i(pg), .judge_evt_i(jd), .sort_lo_evt_i(second_param_low),
    .sort_hi_evt_i(second_param_high), .rsp_valid_o(rv_ns), .rsp_value_o(val_ns),
    .rsp_keyword_o(), .rsp_header_o(), .cmd_reject_o(), .freq_1k_o(),
    .handshake_o(), .header_on_o(), .summary_o());
  initial begin
    forever #10 mclk_i = ~mclk_i;
  end
  task automatic check(input string what, input logic [15:0] seen, exp);
    compares++;
    if (seen !== exp) begin
      failures++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic report_and_stop;
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : report_and_stop
  task automatic w(input ecsr_cmd_t c, input logic [1:0] i,
                   input logic [15:0] n, input logic [3:0] f);
    host.send(c, i, n, f, HS_NONE, 1'b1);
  endtask : w
  // a query reply stands exactly one cycle after the command
  task automatic q(input ecsr_cmd_t c, input logic [1:0] i);
    host.send(c, i, 16'h0000, 4'h0, HS_NONE, 1'b1);
    check("rsp_valid", rv, 16'h0001);
  endtask : q
  task automatic evt(input logic [6:0] p, j, input logic [7:0] lo, hi,
                     input logic [2:0] e);
    @(posedge mclk_i);
    pg <= p;
    jd <= j;
    second_param_low <= lo;
    second_param_high <= hi;
    {oe, fe, pe} <= e;
    @(posedge mclk_i);
    {pg, jd, second_param_low, second_param_high, oe, fe, pe} <= '0;
    repeat (2) @(posedge mclk_i);
    #1;
  endtask : evt
  initial begin
    #1ms;
    failures++;
    report_and_stop();
  end
  initial begin
    repeat (4) @(posedge mclk_i);
    resetn_i <= 1'b1;
    #1;
    check("header_on", hon, 16'h0001);
    check("handshake", hs, HS_NONE);
    for (int i = 0; i < 4; i++) begin
      q(CMD_ESE_Q, 2'(i));
      check("mask", val, 16'h0000);
      check("header", rh, 16'h0001);
      w(CMD_ESE_W, 2'(i), 16'(i * 64 + 3), 4'h0);
      q(CMD_ESE_Q, 2'(i));
      q(CMD_ESE_Q, 2'(i));
      check("mask", val, 16'(i * 64 + 3));
    end
    w(CMD_ESE_W, 2'h2, 16'h0003, 4'h8);
    q(CMD_ESE_Q, 2'h2);
    check("mask2", val, 16'h0004);
    w(CMD_ESE_W, 2'h2, 16'h0100, 4'h0);
    check("reject", rej, 16'h0001);
    w(CMD_ESE_W, 2'h2, 16'h00ff, 4'h7);
    check("reject", rej, 16'h0000);
    q(CMD_ESE_Q, 2'h2);
    check("mask2", val, 16'h00ff);
    w(CMD_ESE_W, 2'h1, 16'h0040, 4'h0);
    $display("test masks done");
    evt(7'h7f, 7'h52, 8'h01, 8'hc0, 3'h0);
    check("summary", sum, 16'h000f);
    q(CMD_ESR_Q, 2'h1);
    check("event1", val, 16'h0052);
    check("header", rh, 16'h0000);
    q(CMD_ESR_Q, 2'h1);
    check("event1", val, 16'h0000);
    q(CMD_ESR_Q, 2'h0);
    check("event0", val, 16'h007f);
    q(CMD_ESR_Q, 2'h2);
    check("event2", val, 16'h0001);
    check("nosort_valid", rv_ns, 16'h0001);
    check("event2_nosort", val_ns, 16'h0000);
    q(CMD_ESR_Q, 2'h3);
    check("event3", val, 16'h00c0);
    check("event3_nosort", val_ns, 16'h0000);
    evt(7'h00, 7'h10, 8'h00, 8'h00, 3'h0);
    check("summary", sum, 16'h0000);
    $display("test events done");
    for (int b = 0; b < 3; b++) begin
      evt(7'h00, 7'h00, 8'h00, 8'h00, 3'(1 << b));
      q(CMD_ERR_Q, 2'h0);
      check("link_err", val, 16'(1 << b));
      check("header", rh, 16'h0000);
      q(CMD_ERR_Q, 2'h0);
      check("link_err", val, 16'h0000);
    end
    $display("test errors done");
    host.send(CMD_HDR_W, 2'h0, 16'h0000, 4'h0, HS_NONE, 1'b0);
    check("header_on", hon, 16'h0000);
    q(CMD_ESE_Q, 2'h1);
    check("header", rh, 16'h0000);
    q(CMD_HDR_Q, 2'h0);
    check("hdr_reply", val, 16'h0000);
    check("hdr_kw", ck, 16'h0001);
    w(CMD_FREQ_W, 2'h0, 16'h0078, 4'h0);
    check("freq_1k", f1k, 16'h0000);
    w(CMD_FREQ_W, 2'h0, 16'h01f4, 4'h0);
    check("reject", rej, 16'h0001);
    q(CMD_FREQ_Q, 2'h0);
    check("freq", val, 16'h0078);
    check("freq_kw", ck, 16'h0000);
    w(CMD_FREQ_W, 2'h0, 16'h03e7, 4'h8);
    check("freq_1k", f1k, 16'h0001);
    q(CMD_FREQ_Q, 2'h0);
    check("freq", val, 16'h03e8);
    for (int h = 0; h < 4; h++) begin
      host.send(CMD_HAND_W, 2'h0, 16'h0000, 4'h0, ecsr_hand_t'(h), 1'b1);
      check("handshake", hs, 16'(h));
      q(CMD_HAND_Q, 2'h0);
      check("hand_kw", ck, 16'h0001);
      check("hand_reply", val, 16'(h));
    end
    $display("test settings done");
    @(posedge mclk_i);
    resetn_i <= 1'b0;
    repeat (2) @(posedge mclk_i);
    resetn_i <= 1'b1;
    #1;
    check("header_on", hon, 16'h0001);
    check("freq_1k", f1k, 16'h0001);
    q(CMD_ESE_Q, 2'h3);
    check("mask", val, 16'h0000);
    $display("test reset done");
    report_and_stop();
  end
endmodule : ecsr_top_bench
